// File: rtl/refdiv_host.sv
// host end: shifts one 24-bit word out and pulses the load strobe
`timescale 1ns/1ps
`default_nettype none
`include "refdiv_cfg.svh"
module refdiv_host #(
  parameter int HALF = `HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  refdiv_if.host link,
  input wire logic send_valid,
  output logic send_ready,
  input wire logic [`ADDR_BITS-1:0] send_addr,
  input wire logic [`WORD_BITS-`ADDR_BITS-1:0] send_data,
  output logic send_done
);
  // tick counter is 16 bits wide
  if (HALF < 1 || HALF > 65536) begin : g_half_check
    $error("HALF out of range");
  end
  typedef enum logic [1:0] {st_idle, st_low, st_high, st_strobe} host_state_t;
  host_state_t state_q;
  logic [`WORD_BITS-1:0] word_q;
  logic [4:0] bits_q;
  logic [15:0] tick_q;
  logic sd_q, sc_q, le_q;
  wire tick_end = (tick_q == 16'(HALF - 1));
  wire [`DIV_BITS-1:0] div_in = send_data[`DIV_BITS-1:0];
  // refuse unsupported divide values for this word
  wire div_ok = (send_addr != `ADDR_REFDIV) || ((div_in >= `DIV_MIN) && (div_in <= `DIV_MAX));
  assign send_ready = (state_q == st_idle) && div_ok;
  assign link.serial_data = sd_q;
  assign link.serial_clock = sc_q;
  assign link.word_load_strobe = le_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      word_q <= '0;
      bits_q <= 5'h0;
      tick_q <= 16'h0;
      sd_q <= 1'b0;
      sc_q <= 1'b0;
      le_q <= 1'b0;
      send_done <= 1'b0;
    end else begin
      send_done <= 1'b0;
      tick_q <= tick_end ? 16'h0 : tick_q + 16'h1;
      unique case (state_q)
        st_idle: begin
          tick_q <= 16'h0;
          if (send_valid && send_ready) begin
            word_q <= {send_data, send_addr};
            bits_q <= 5'(`WORD_BITS);
            state_q <= st_low;
          end
        end
        st_low: begin
          if (tick_q == 16'h0) begin
            sd_q <= word_q[`WORD_BITS-1];
            word_q <= {word_q[`WORD_BITS-2:0], 1'b0};
          end
          if (tick_end) begin
            sc_q <= 1'b1;
            bits_q <= bits_q - 5'h1;
            state_q <= st_high;
          end
        end
        st_high: begin
          if (tick_end) begin
            sc_q <= 1'b0;
            if (bits_q == 5'h0) begin
              le_q <= 1'b1;
              state_q <= st_strobe;
            end else begin
              state_q <= st_low;
            end
          end
        end
        st_strobe: begin
          if (tick_end) begin
            le_q <= 1'b0;
            send_done <= 1'b1;
            state_q <= st_idle;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: include/refdiv_cfg.svh
// constants of the reference-divider configuration word and its serial link
`ifndef REFDIV_CFG_SVH
`define REFDIV_CFG_SVH

`define WORD_BITS 24
`define ADDR_BITS 2
`define ADDR_REFDIV 2'h2
`define DATA_OFS 2
`define DIV_LSB 2
`define DIV_BITS 15
`define POL_POS 17
`define CUR_LSB 18
`define CUR_BITS 4
`define DBL_POS 22
`define SPD_POS 23
`define DIV_MIN 15'h0003
`define DIV_MAX 15'h7fff
`define CUR_STEP_UA 100
`define CUR_BASE_UA 100
`define LINK_PERIOD_NS 200
`define CORE_PERIOD_NS 25
`define HALF_CYCLES ((`LINK_PERIOD_NS / `CORE_PERIOD_NS) / 2)

`endif

// File: include/refdiv_pkg.sv
// types used by the device end of the reference-divider link
package refdiv_pkg;
  typedef enum logic {speed_slow, speed_fast} cal_speed_t;
  typedef struct packed {
    cal_speed_t cal_speed;
    logic pump_supply_doubler_enable;
    logic [3:0] pump_current_word;
    logic detector_polarity;
    logic [14:0] reference_divide_value;
  } refdiv_word_t;
endpackage

// File: include/refdiv_if.sv
// three-wire serial load link between host and synthesizer
`timescale 1ns/1ps
`default_nettype none
interface refdiv_if;
  logic serial_data;
  logic serial_clock;
  logic word_load_strobe;
  modport host (output serial_data, output serial_clock, output word_load_strobe);
  modport device (input serial_data, input serial_clock, input word_load_strobe);
endinterface
`default_nettype wire

// File: rtl/refdiv_device.sv
// synthesizer end: serial shift register and reference-divider latch
`timescale 1ns/1ps
`default_nettype none
`include "refdiv_cfg.svh"
module refdiv_device (
  input wire logic core_clk,
  input wire logic rst_n,
  refdiv_if.device link,
  output logic [14:0] reference_divide_value,
  output logic detector_polarity,
  output logic pump_weight_one,
  output logic pump_weight_two,
  output logic pump_weight_four,
  output logic pump_weight_eight,
  output logic pump_supply_doubler_enable,
  output logic cal_speed_fast,
  output logic [10:0] pump_current_ua,
  output logic word_loaded
);
  // ==========================================
  // pin synchronisers
  logic [1:0] sd_q, sc_q, le_q;
  logic sc_prev_q, le_prev_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_q <= 2'h0;
      sc_q <= 2'h0;
      le_q <= 2'h0;
      sc_prev_q <= 1'b0;
      le_prev_q <= 1'b0;
    end else begin
      sd_q <= {sd_q[0], link.serial_data};
      sc_q <= {sc_q[0], link.serial_clock};
      le_q <= {le_q[0], link.word_load_strobe};
      sc_prev_q <= sc_q[1];
      le_prev_q <= le_q[1];
    end
  end
  wire sc_rise = sc_q[1] & ~sc_prev_q;
  wire le_rise = le_q[1] & ~le_prev_q;

  // ==========================================
  // shift register and latch
  logic [`WORD_BITS-1:0] shift_q;
  refdiv_pkg::refdiv_word_t latch_q;
  wire addr_hit = (shift_q[`ADDR_BITS-1:0] == `ADDR_REFDIV);
  wire do_load = le_rise & addr_hit;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
      latch_q <= '0;
      word_loaded <= 1'b0;
    end else begin
      if (sc_rise) begin
        shift_q <= {shift_q[`WORD_BITS-2:0], sd_q[1]};
      end
      if (do_load) begin
        latch_q <= shift_q[`WORD_BITS-1:`DATA_OFS];
      end
      word_loaded <= do_load;
    end
  end

  // ==========================================
  // latched fields
  assign reference_divide_value = latch_q.reference_divide_value;
  assign detector_polarity = latch_q.detector_polarity;
  assign pump_weight_one = latch_q.pump_current_word[0];
  assign pump_weight_two = latch_q.pump_current_word[1];
  assign pump_weight_four = latch_q.pump_current_word[2];
  assign pump_weight_eight = latch_q.pump_current_word[3];
  assign pump_supply_doubler_enable = latch_q.pump_supply_doubler_enable;
  assign cal_speed_fast = (latch_q.cal_speed == refdiv_pkg::speed_fast);
  // current in microamps
  assign pump_current_ua = 11'(`CUR_BASE_UA)
    + 11'(latch_q.pump_current_word) * 11'(`CUR_STEP_UA);
endmodule
`default_nettype wire

// File: testbench/refdiv_props.sv
// checker: link framing and latch results
`timescale 1ns/1ps
`default_nettype none
module refdiv_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serial_data,
  input wire logic serial_clock,
  input wire logic word_load_strobe,
  input wire logic word_loaded,
  input wire logic [14:0] reference_divide_value,
  input wire logic [10:0] pump_current_ua
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic clk_q;
  logic [23:0] sh_q;
  // ==========
  // shadow of the shifted word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      sh_q <= 24'h000000;
    end else begin
      clk_q <= serial_clock;
      if (serial_clock && !clk_q)
        sh_q <= {sh_q[22:0], serial_data};
    end
  end
  sequence strobe_up; $rose(word_load_strobe); endsequence
  sequence strobe_held; word_load_strobe [*4]; endsequence
  // ==========
  // properties
  strobe_hold_a: assert property (strobe_up |-> strobe_held)
    else $error("strobe too short");
  strobe_idle_a: assert property (word_load_strobe |-> !serial_clock)
    else $error("clock during strobe");
  data_stable_a: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_data))
    else $error("data moved while clock high");
  load_cause_a: assert property (word_loaded |-> $past(word_load_strobe, 3))
    else $error("load without strobe");
  load_pulse_a: assert property (word_loaded |=> !word_loaded)
    else $error("load pulse too long");
  addr_match_a: assert property (word_loaded |-> sh_q[1:0] == 2'h2)
    else $error("load with wrong address");
  div_field_a: assert property (word_loaded |-> reference_divide_value == sh_q[16:2])
    else $error("divide value wrong");
  pump_cur_a: assert property (word_loaded |-> pump_current_ua == 11'h064 + 11'h064 * sh_q[21:18])
    else $error("pump current wrong");
  latch_hold_a: assert property ($changed(reference_divide_value) |-> word_loaded)
    else $error("latch moved without load");
endmodule
`default_nettype wire

// File: testbench/tb.sv
// bench: host and device joined, latched words checked
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic [1:0] adr = 2'h0;
  logic [21:0] dat = 22'h000000;
  logic [21:0] last = 22'h000000;
  logic [21:0] q[$];
  int error_cnt = 0;
  int checks_done = 0;
  wire rdy, done, wl, pol, dbl, fast;
  wire [3:0] w;
  wire [14:0] rdv;
  wire [10:0] cur;
  wire [21:0] seen = {fast, dbl, w, pol, rdv};
  always #12.5 core_clk = ~core_clk;
  refdiv_if lnk();
  refdiv_host refdiv_host_inst (.core_clk(core_clk), .rst_n(rst_n), .link(lnk),
    .send_valid(vld), .send_ready(rdy), .send_addr(adr), .send_data(dat), .send_done(done));
  refdiv_device refdiv_device_inst (.core_clk(core_clk), .rst_n(rst_n), .link(lnk),
    .reference_divide_value(rdv), .detector_polarity(pol), .pump_weight_one(w[0]),
    .pump_weight_two(w[1]), .pump_weight_four(w[2]), .pump_weight_eight(w[3]),
    .pump_supply_doubler_enable(dbl), .cal_speed_fast(fast), .pump_current_ua(cur),
    .word_loaded(wl));
  refdiv_props refdiv_props_inst (.core_clk(core_clk), .rst_n(rst_n),
    .serial_data(lnk.serial_data), .serial_clock(lnk.serial_clock),
    .word_load_strobe(lnk.word_load_strobe), .word_loaded(wl),
    .reference_divide_value(rdv), .pump_current_ua(cur));
  // ==========
  // checking and verdict
  task automatic chk(input logic [21:0] s, input logic [21:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [21:0] mk();
    logic [21:0] d;
    d = 22'($urandom);
    d[14:0] = 15'(3 + $urandom % 32765);
    return d;
  endfunction
  task automatic send(input logic [1:0] a, input logic [21:0] d);
    int n;
    n = 0;
    adr <= a;
    dat <= d;
    vld <= 1'b1;
    do @(posedge core_clk); while (rdy !== 1'b1 && ++n < 50);
    vld <= 1'b0;
    if (a == 2'h2) begin
      q.push_back(d);
      last = d;
    end
    do @(posedge core_clk); while (done !== 1'b1 && ++n < 500);
    if (n >= 50 && done !== 1'b1) begin
      chk(22'h000001, 22'h000000);
      give_verdict();
    end
  endtask
  // ==========
  // results at each load
  always @(posedge core_clk) begin
    if (wl === 1'b1) begin
      if (q.size() == 0)
        chk(22'h000001, 22'h000000);
      else begin
        chk(seen, q[0]);
        chk(22'(cur), 22'(11'h064 + 11'h064 * q[0][19:16]));
        void'(q.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(32'h0303));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int c = 0; c < 16; c++)
      send(2'h2, {1'b1, 1'(mk()), 4'(c), 16'(mk())});
    send(2'h2, 22'h000003);
    send(2'h2, 22'h3f7fff);
    for (int a = 0; a < 4; a++) begin
      send(2'(a), mk());
      chk(seen, last);
    end
    adr <= 2'h2;
    dat <= 22'h000002;
    repeat (2) @(posedge core_clk);
    chk(22'(rdy), 22'h000000);
    give_verdict();
  end
endmodule
`default_nettype wire
